// file: src/tpc_event_counter.sv
// Three-channel 16-bit two-phase (quadrature) event counter with register port and interrupt
//
// Contract
// - Count events come only from the channel in and out pins, never an internal clock.
// - Count direction follows the phase relation of the two pins, not software.
// - On overflow or underflow the counter loads the reload value and keeps counting.
// - With free-run selected the counter just wraps and never loads the reload value.
// - Counting up with reload overflows once per FFFF16 - n + 1 events.
// - Counting down with reload underflows once per n + 1 events.
// - The counter follows count events only while its start flag is 1.
// - Clearing the start flag to 0 stops counting and holds the value.
// - Each overflow up or underflow down raises the channel interrupt request.
// - Reading a timer register returns the current counter value.
// - Writing a timer register while stopped loads both reload register and counter.
// - Writing while running loads only the reload; counter takes it at next reload.
// - Normal: up on in-pin rise, down on in-pin fall, while out pin high.
// - Times four: count up every edge of both pins when in rises with out high.
// - Times four: count down every edge of both pins when in falls with out high.
// - Channel two is fixed normal, channel four fixed times four, no selection.
// - Channel three lets software choose normal or times four processing.
//
// The register offsets and the plain strobed port were decided locally.
`include "tpc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module tpc_event_counter
   import tpc_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic NRST_I,
   input wire logic [7:0] BUS_ADDR_I,
   input wire logic [15:0] BUS_WDATA_I,
   input wire logic BUS_WR_I,
   input wire logic BUS_RD_I,
   output logic [15:0] BUS_RDATA_O,
   input wire logic [2:0] CHANNEL_IN_PIN_I,
   input wire logic [2:0] CHANNEL_OUT_PIN_I,
   output logic [2:0] CH_IRQ_O,
   output logic IRQ_O
);

   // ****************************************************************
   // Register port decode
   // ****************************************************************
   tpc_bus_req_t req;
   logic [2:0] tmr_wr;
   logic start_wr;
   logic mode_wr;
   logic stat_wr;
   logic mask_wr;

   assign req.addr = BUS_ADDR_I;
   assign req.wdata = BUS_WDATA_I;
   assign req.wr = BUS_WR_I;
   assign req.rd = BUS_RD_I;

   assign tmr_wr[0] = req.wr && (req.addr == `TPC_OFS_TMR2);
   assign tmr_wr[1] = req.wr && (req.addr == `TPC_OFS_TMR3);
   assign tmr_wr[2] = req.wr && (req.addr == `TPC_OFS_TMR4);
   assign start_wr = req.wr && (req.addr == `TPC_OFS_START);
   assign mode_wr = req.wr && (req.addr == `TPC_OFS_MODE);
   assign stat_wr = req.wr && (req.addr == `TPC_OFS_IRQ_STAT);
   assign mask_wr = req.wr && (req.addr == `TPC_OFS_IRQ_MASK);

   // ****************************************************************
   // Control registers
   // ****************************************************************
   logic [2:0] start_q;
   logic [2:0] free_q;
   logic x4_sel_q;

   // Clearing a start bit freezes the count but not the pin history, so a
   // restart compares against the live pin levels, never a stale one.
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         start_q <= `TPC_RST_START;
      end else if (start_wr) begin
         start_q <= req.wdata[2:0];
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         {x4_sel_q, free_q} <= `TPC_RST_MODE;
      end else if (mode_wr) begin
         free_q <= req.wdata[`TPC_MODE_FREE_LSB +: 3];
         x4_sel_q <= req.wdata[`TPC_MODE_X4_BIT];
      end
   end

   // ****************************************************************
   // Pin history
   // ****************************************************************
   // Pins are taken as already synchronous, so one stage of history
   // is all the edge detectors need.
   // History resets low like an idle encoder; a pin already high at release
   // reads as a rise, which is harmless while start is still 0.
   logic [2:0] in_prev_q;
   logic [2:0] out_prev_q;

   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         in_prev_q <= 3'h0;
         out_prev_q <= 3'h0;
      end else begin
         in_prev_q <= CHANNEL_IN_PIN_I;
         out_prev_q <= CHANNEL_OUT_PIN_I;
      end
   end

   // ****************************************************************
   // Per-channel decoder and counter
   // ****************************************************************
   logic [15:0] cnt_all [3];
   logic [2:0] ovf_ev;
   logic [2:0] udf_ev;
   logic [2:0] dir_up;

   genvar g;
   generate
      for (g = 0; g < `TPC_NUM_CH; g++) begin : g_ch
         tpc_style_t style;
         tpc_step_t step;
         logic in_now;
         logic out_now;
         logic in_rise;
         logic in_fall;
         logic out_rise;
         logic out_fall;
         logic [15:0] cnt_q;
         logic [15:0] cnt_d;
         logic [15:0] rld_q;
         logic [15:0] rld_d;
         logic dir_q;
         logic wrap_up;
         logic wrap_dn;
         logic run;
         logic both_moved;
         logic x4_up;
         logic x4_dn;

         // Channel 2 and 4 have a fixed style, channel 3 follows software
         if (g == 0) begin : g_fix_norm
            assign style = TPC_NORMAL;
         end else if (g == 2) begin : g_fix_x4
            assign style = TPC_X4;
         end else begin : g_sel
            assign style = x4_sel_q ? TPC_X4 : TPC_NORMAL;
         end

         assign in_now = CHANNEL_IN_PIN_I[g];
         assign out_now = CHANNEL_OUT_PIN_I[g];
         assign in_rise = in_now && !in_prev_q[g];
         assign in_fall = !in_now && in_prev_q[g];
         assign out_rise = out_now && !out_prev_q[g];
         assign out_fall = !out_now && out_prev_q[g];

         // In times four every single-pin edge counts; the direction is read
         // from the level of the pin that stood still.
         assign both_moved = (in_rise || in_fall) && (out_rise || out_fall);
         assign x4_up = (in_rise && out_now) || (out_fall && in_now) ||
                        (in_fall && !out_now) || (out_rise && !in_now);
         assign x4_dn = (in_fall && out_now) || (out_rise && in_now) ||
                        (in_rise && !out_now) || (out_fall && !in_now);
         assign run = start_q[g];

         // Direction comes from which pin leads; in times four both changing at once is
         // a lost phase step and counts nothing, while normal still counts it.
         always_comb begin
            step.up = 1'b0;
            step.down = 1'b0;
            case (style)
               TPC_NORMAL: begin
                  step.up = in_rise && out_now;
                  step.down = in_fall && out_now;
               end
               TPC_X4: begin
                  if (!both_moved) begin
                     step.up = x4_up;
                     step.down = x4_dn;
                  end
               end
               default: begin
                  step.up = 1'b0;
                  step.down = 1'b0;
               end
            endcase
         end

         assign wrap_up = start_q[g] && step.up && (cnt_q == `TPC_CNT_MAX);
         assign wrap_dn = start_q[g] && step.down && (cnt_q == `TPC_CNT_MIN);

         // Reload register: every write lands here, running or not
         always_comb begin
            rld_d = rld_q;
            if (tmr_wr[g]) begin
               rld_d = req.wdata;
            end
         end

         always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
            if (!NRST_I) begin
               rld_q <= `TPC_RST_RELOAD;
            end else begin
               rld_q <= rld_d;
            end
         end

         // A reload in the same cycle as a write takes the freshly written
         // value, so software never sees the stale one come back.
         always_comb begin
            cnt_d = cnt_q;
            if (run) begin
               if (wrap_up || wrap_dn) begin
                  // Free-run leaves the reload register for software alone
                  if (free_q[g]) begin
                     cnt_d = wrap_up ? `TPC_CNT_MIN : `TPC_CNT_MAX;
                  end else begin
                     cnt_d = rld_d;
                  end
               end else if (step.up) begin
                  cnt_d = cnt_q + 16'h0001;
               end else if (step.down) begin
                  cnt_d = cnt_q - 16'h0001;
               end
            end else if (tmr_wr[g]) begin
               cnt_d = req.wdata;
            end
         end

         always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
            if (!NRST_I) begin
               cnt_q <= `TPC_RST_CNT;
            end else begin
               cnt_q <= cnt_d;
            end
         end

         // Last direction seen, readable for software diagnostics
         always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
            if (!NRST_I) begin
               dir_q <= 1'b0;
            end else if (start_q[g] && (step.up || step.down)) begin
               dir_q <= step.up;
            end
         end

         assign cnt_all[g] = cnt_q;
         assign ovf_ev[g] = wrap_up;
         assign udf_ev[g] = wrap_dn;
         assign dir_up[g] = dir_q;
      end
   endgenerate

   // ****************************************************************
   // Interrupt status and mask
   // ****************************************************************
   logic [5:0] stat_q;
   logic [5:0] mask_q;
   logic [5:0] stat_set;
   logic [2:0] ch_irq_q;
   logic [5:0] stat_clr;
   logic [2:0] wrap_ev;

   assign stat_set = {udf_ev, ovf_ev};
   assign wrap_ev = ovf_ev | udf_ev;

   // Only bits written as one are cleared; zeros leave the status alone
   always_comb begin
      stat_clr = 6'h00;
      if (stat_wr) begin
         stat_clr = req.wdata[5:0];
      end
   end

   // Write-one-to-clear; a new event in the clearing cycle still sets
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         stat_q <= `TPC_RST_STAT;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | stat_set;
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         mask_q <= `TPC_RST_MASK;
      end else if (mask_wr) begin
         mask_q <= req.wdata[5:0];
      end
   end

   // Per-channel request pulse, one cycle after the wrap
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ch_irq_q <= 3'h0;
      end else begin
         ch_irq_q <= wrap_ev;
      end
   end

   assign CH_IRQ_O = ch_irq_q;
   assign IRQ_O = |(stat_q & mask_q);

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [15:0] rdata_d;
   logic [15:0] rdata_q;
   logic [15:0] phase_word;

   // Live pin levels beside the last direction seen per channel
   assign phase_word = {7'h00, dir_up, CHANNEL_OUT_PIN_I, CHANNEL_IN_PIN_I};

   always_comb begin
      rdata_d = 16'h0000;
      case (req.addr)
         `TPC_OFS_TMR2: rdata_d = cnt_all[0];
         `TPC_OFS_TMR3: rdata_d = cnt_all[1];
         `TPC_OFS_TMR4: rdata_d = cnt_all[2];
         `TPC_OFS_START: rdata_d = {13'h0000, start_q};
         `TPC_OFS_MODE: rdata_d = {12'h000, x4_sel_q, free_q};
         `TPC_OFS_IRQ_STAT: rdata_d = {10'h000, stat_q};
         `TPC_OFS_IRQ_MASK: rdata_d = {10'h000, mask_q};
         `TPC_OFS_PHASE: rdata_d = phase_word;
         default: rdata_d = 16'h0000;
      endcase
   end

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rdata_q <= 16'h0000;
      end else if (req.rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign BUS_RDATA_O = rdata_q;

endmodule : tpc_event_counter

`default_nettype wire

// file: src/tpc_cfg.svh
// Register offsets, field positions and reset values of the two-phase event counter
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses on the plain register port)
// ****************************************************************
`define TPC_OFS_TMR2 8'h00
`define TPC_OFS_TMR3 8'h04
`define TPC_OFS_TMR4 8'h08
`define TPC_OFS_START 8'h0C
`define TPC_OFS_MODE 8'h10
`define TPC_OFS_IRQ_STAT 8'h14
`define TPC_OFS_IRQ_MASK 8'h18
`define TPC_OFS_PHASE 8'h1C

// ****************************************************************
// Field positions
// ****************************************************************
`define TPC_MODE_FREE_LSB 0
`define TPC_MODE_X4_BIT 3
`define TPC_STAT_OVF_LSB 0
`define TPC_STAT_UDF_LSB 3
`define TPC_PHASE_IN_LSB 0
`define TPC_PHASE_OUT_LSB 3
`define TPC_PHASE_DIR_LSB 6

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define TPC_NUM_CH 3
`define TPC_CNT_W 16
`define TPC_CNT_MAX 16'hFFFF
`define TPC_CNT_MIN 16'h0000
`define TPC_RST_CNT 16'h0000
`define TPC_RST_RELOAD 16'h0000
`define TPC_RST_START 3'h0
`define TPC_RST_MODE 4'h0
`define TPC_RST_STAT 6'h00
`define TPC_RST_MASK 6'h00

`endif

// file: src/tpc_pkg.sv
// Types shared by the two-phase event counter
package tpc_pkg;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } tpc_bus_req_t;

   // One decoded count step of a channel
   typedef struct packed {
      logic up;
      logic down;
   } tpc_step_t;

   // Decoding style of a channel
   typedef enum logic [1:0] {
      TPC_NORMAL = 2'b01,
      TPC_X4 = 2'b10
   } tpc_style_t;

endpackage : tpc_pkg

// file: testbench/tpc_event_counter_assertions.sv
// Port-level assertions for the two-phase event counter
`include "tpc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tpc_event_counter_assertions (
   input wire logic CLK_SYS_I,
   input wire logic NRST_I,
   input wire logic [7:0] BUS_ADDR_I,
   input wire logic [15:0] BUS_WDATA_I,
   input wire logic BUS_WR_I,
   input wire logic BUS_RD_I,
   input wire logic [15:0] BUS_RDATA_O,
   input wire logic [2:0] CHANNEL_IN_PIN_I,
   input wire logic [2:0] CHANNEL_OUT_PIN_I,
   input wire logic [2:0] CH_IRQ_O,
   input wire logic IRQ_O
);
   logic [2:0] start_q;
   logic [5:0] mask_q;
   logic [2:0] pin_in_q;
   logic [2:0] pin_out_q;
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!NRST_I);
   // Shadow copies, since the checker may not look inside the block
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         start_q <= 3'h0;
         mask_q <= 6'h00;
      end else if (BUS_WR_I) begin
         if (BUS_ADDR_I == `TPC_OFS_START) start_q <= BUS_WDATA_I[2:0];
         if (BUS_ADDR_I == `TPC_OFS_IRQ_MASK) mask_q <= BUS_WDATA_I[5:0];
      end
   end
   // Pin levels one edge back, so a request can be tied to the move that caused it
   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pin_in_q <= 3'h0;
         pin_out_q <= 3'h0;
      end else begin
         pin_in_q <= CHANNEL_IN_PIN_I;
         pin_out_q <= CHANNEL_OUT_PIN_I;
      end
   end
   a_rdata_idle: assert property (BUS_RDATA_O != 16'h0000 |-> $past(BUS_RD_I))
      else $error("read data outside answer cycle");
   a_rdata_unmap: assert property ($past(BUS_RD_I) && $past(BUS_ADDR_I) > 8'h1C
      |-> BUS_RDATA_O == 16'h0000) else $error("unmapped read not zero");
   a_irq_pulse: assert property ((CH_IRQ_O & ~$past((CHANNEL_IN_PIN_I ^ pin_in_q) |
      (CHANNEL_OUT_PIN_I ^ pin_out_q))) == 3'h0)
      else $error("channel request without a pin move");
   a_irq_pin: assert property (CH_IRQ_O[0] |->
      $past(CHANNEL_IN_PIN_I[0]) != $past(CHANNEL_IN_PIN_I[0], 2))
      else $error("wrap without in pin change");
   a_stop_quiet: assert property (CH_IRQ_O[0] |-> $past(start_q[0]))
      else $error("wrap while stopped");
   a_irq_masked: assert property (IRQ_O |-> mask_q != 6'h00)
      else $error("interrupt with all masked");
   a_irq_cause: assert property ($rose(IRQ_O) && !$past(BUS_WR_I)
      |-> ##[0:1] CH_IRQ_O != 3'h0) else $error("interrupt without a wrap");
   a_stat_clear: assert property ($past(BUS_WR_I && BUS_ADDR_I == `TPC_OFS_IRQ_STAT &&
      &BUS_WDATA_I[5:0]) && $past(start_q) == 3'h0 |-> !IRQ_O)
      else $error("interrupt stays after clear");
endmodule : tpc_event_counter_assertions
bind tpc_event_counter tpc_event_counter_assertions i_tpc_event_counter_assertions (
   .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .BUS_ADDR_I(BUS_ADDR_I),
   .BUS_WDATA_I(BUS_WDATA_I), .BUS_WR_I(BUS_WR_I), .BUS_RD_I(BUS_RD_I),
   .BUS_RDATA_O(BUS_RDATA_O), .CHANNEL_IN_PIN_I(CHANNEL_IN_PIN_I),
   .CHANNEL_OUT_PIN_I(CHANNEL_OUT_PIN_I), .CH_IRQ_O(CH_IRQ_O), .IRQ_O(IRQ_O));
`default_nettype wire

// file: testbench/tpc_encoder_model.sv
// Quadrature encoder model driving the in and out pins of all three channels
`timescale 1ns/1ns
`default_nettype none
module tpc_encoder_model (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic step_i,
   input wire logic up_i,
   output logic [2:0] in_pin_o,
   output logic [2:0] out_pin_o
);
   logic [1:0] pos_q;
   // Gray order (in,out) 01,11,10,00: one pin moves per step, never both
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) pos_q <= 2'h3;
      else if (step_i) pos_q <= up_i ? pos_q + 2'h1 : pos_q - 2'h1;
   end
   // Out pin always acts as second phase, as the port function set by software
   assign in_pin_o = {3{pos_q[0] ^ pos_q[1]}};
   assign out_pin_o = {3{~pos_q[1]}};
endmodule : tpc_encoder_model
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the two-phase event counter
`include "tpc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk, nrst, wr, rd, step, up, irq, rd_q;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, r3;
   logic [2:0] in_pin, out_pin, ch_irq;
   logic [15:0] exp_q[$];
   logic [7:0] pulses [3] = '{8'h00, 8'h00, 8'h00};
   int num_errors, cmp_count, cycles, seed;
   tpc_event_counter i_tpc_event_counter (.CLK_SYS_I(clk), .NRST_I(nrst), .BUS_ADDR_I(addr),
      .BUS_WDATA_I(wdata), .BUS_WR_I(wr), .BUS_RD_I(rd), .BUS_RDATA_O(rdata),
      .CHANNEL_IN_PIN_I(in_pin), .CHANNEL_OUT_PIN_I(out_pin), .CH_IRQ_O(ch_irq), .IRQ_O(irq));
   tpc_encoder_model i_tpc_encoder_model (.clk_i(clk), .nrst_i(nrst), .step_i(step),
      .up_i(up), .in_pin_o(in_pin), .out_pin_o(out_pin));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic test_done;
      $display("Compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   task automatic chk16(input logic [15:0] e, input logic [15:0] s);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("FAIL rdata exp %h got %h", e, s);
      end
   endtask : chk16
   task automatic chk1(input logic e, input logic s);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("FAIL irq exp %b got %b", e, s);
      end
   endtask : chk1
   task automatic chk8(input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("FAIL ch_irq pulses exp %h got %h", e, s);
      end
   endtask : chk8
   // An idle edge after each strobe keeps two drives of one signal apart
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask : rd_reg
   task automatic rd3(input logic [15:0] e2, input logic [15:0] e3, input logic [15:0] e4);
      rd_reg(`TPC_OFS_TMR2, e2);
      rd_reg(`TPC_OFS_TMR3, e3);
      rd_reg(`TPC_OFS_TMR4, e4);
   endtask : rd3
   // Each phase level stands two cycles; normal counts 1, times four counts 4 per 4 steps
   task automatic mv(input logic u, input int n);
      up <= u;
      repeat (n) begin
         step <= 1'b1;
         @(posedge clk);
         step <= 1'b0;
         @(posedge clk);
      end
   endtask : mv
   // Monitor: read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_q) chk16(exp_q.pop_front(), rdata);
      rd_q <= rd;
      for (int i = 0; i < 3; i++) begin
         if (ch_irq[i] === 1'b1) pulses[i] = pulses[i] + 8'h01;
      end
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      nrst = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      step = 1'b0;
      up = 1'b1;
      seed = 90;
      r3 = 16'h0100 | 16'($random(seed)) & 16'h0FFF;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (int a = 0; a <= 32; a += 4) rd_reg(8'(a), 16'h0000);
      wr_reg(`TPC_OFS_TMR2, 16'hFFFE);
      wr_reg(`TPC_OFS_TMR3, r3);
      wr_reg(`TPC_OFS_TMR4, 16'h0002);
      rd3(16'hFFFE, r3, 16'h0002);
      wr_reg(`TPC_OFS_IRQ_MASK, 16'h003F);
      wr_reg(`TPC_OFS_START, 16'h0007);
      mv(1'b1, 8);
      rd3(16'hFFFE, r3 + 16'h0002, 16'h000A);
      rd_reg(`TPC_OFS_PHASE, 16'h01C0);
      rd_reg(`TPC_OFS_IRQ_STAT, 16'h0001);
      chk1(1'b1, irq);
      wr_reg(`TPC_OFS_TMR2, 16'hFFFD);
      rd_reg(`TPC_OFS_TMR2, 16'hFFFE);
      mv(1'b1, 8);
      rd3(16'hFFFD, r3 + 16'h0004, 16'h0012);
      wr_reg(`TPC_OFS_IRQ_STAT, 16'h0001);
      rd_reg(`TPC_OFS_IRQ_STAT, 16'h0000);
      chk1(1'b0, irq);
      wr_reg(`TPC_OFS_START, 16'h0000);
      mv(1'b1, 4);
      rd3(16'hFFFD, r3 + 16'h0004, 16'h0012);
      for (int a = 0; a <= 8; a += 4) wr_reg(8'(a), 16'h0001);
      wr_reg(`TPC_OFS_MODE, 16'h000C);
      rd_reg(`TPC_OFS_MODE, 16'h000C);
      wr_reg(`TPC_OFS_START, 16'h0007);
      mv(1'b0, 8);
      rd3(16'h0001, 16'h0001, 16'hFFF9);
      rd_reg(`TPC_OFS_IRQ_STAT, 16'h0038);
      wr_reg(`TPC_OFS_IRQ_MASK, 16'h0000);
      chk1(1'b0, irq);
      wr_reg(`TPC_OFS_IRQ_MASK, 16'h0020);
      chk1(1'b1, irq);
      wr_reg(`TPC_OFS_START, 16'h0000);
      wr_reg(`TPC_OFS_IRQ_STAT, 16'h003F);
      chk1(1'b0, irq);
      rd_reg(`TPC_OFS_PHASE, 16'h0000);
      repeat (2) @(posedge clk);
      chk8(8'h03, pulses[0]);
      chk8(8'h04, pulses[1]);
      chk8(8'h01, pulses[2]);
      test_done();
   end
endmodule : testbench
`default_nettype wire
